/* hw/ccsc_pkg.sv */
/*
  Constants and carrier types for the charge cycle status controller.
  Assumes one 250 MHz clock (MCLK) and comparator levels already digital.
*/
// Overview of operation
// - Suspend input disables charging while asserted.
// - Below trickle threshold select trickle current.
// - Above trickle, constant current until float.
// - Half hour under trickle latches bad battery.
// - Rising above trickle resumes from bad latch.
// - Latched, falling again before rising above recharge is defective immediately.
// - Latch cleared by power cycle or suspend.
// - Four hour timer starts above recharge in CV.
// - Timer expiry terminates charging completely.
// - After termination, recharge below recharge threshold.
// - Timer resets only after 1.7 ms dip.
// - Lockout cycle or suspend restarts the cycle.
// - High power selects full, else one fifth.
// - Status pin low throughout normal charging.
// - Status released when current under tenth.
// - Fault after release keeps pin released.
// - Fault before release gives blinking 35 kHz carrier.
// - Temperature fault duty 1/16 and 15/16 at 1.5 Hz.
// - Bad battery duty 2/16 and 14/16 at 6.1 Hz.
// - Temperature out of range pauses charging.
// - Temperature fault in CV holds timer count.
`default_nettype none
package ccsc_pkg;
  // Clock rate in Hz
  localparam longint CLK_HZ        = 64'd250000000;
  // Timing figures in their own units
  localparam longint BADBAT_S      = 64'd1800;     // half an hour
  localparam longint SAFETY_S      = 64'd14400;    // four hours
  localparam longint DIP_US        = 64'd1700;     // 1.7 ms dip filter
  localparam longint CARRIER_HZ    = 64'd35000;
  localparam longint BLINK_NTC_MHZ = 64'd1500;     // 1.5 Hz in mHz
  localparam longint BLINK_BAD_MHZ = 64'd6100;     // 6.1 Hz in mHz
  // Derived cycle counts: minima round up, periods round down
  localparam longint BADBAT_CYC    = BADBAT_S * CLK_HZ;
  localparam longint SAFETY_CYC    = SAFETY_S * CLK_HZ;
  localparam longint DIP_CYC       = (DIP_US * CLK_HZ + 64'd999999) / 64'd1000000;
  // Carrier is split in sixteenths, so one slot is period/16
  localparam longint SLOT_CYC      = CLK_HZ / (CARRIER_HZ * 64'd16);
  // Half a blink period in cycles
  localparam longint HALF_NTC_CYC  = (CLK_HZ * 64'd1000) / (BLINK_NTC_MHZ * 64'd2);
  localparam longint HALF_BAD_CYC  = (CLK_HZ * 64'd1000) / (BLINK_BAD_MHZ * 64'd2);
  // Duty levels in sixteenths
  localparam logic [3:0] DUTY_NTC_LO = 4'h1;
  localparam logic [3:0] DUTY_NTC_HI = 4'hf;
  localparam logic [3:0] DUTY_BAD_LO = 4'h2;
  localparam logic [3:0] DUTY_BAD_HI = 4'he;
  // Counter widths
  localparam int TW = 44;
  // Charge phase
  typedef enum logic [2:0] {
    CCSC_OFF, CCSC_TRICKLE, CCSC_CC, CCSC_CV, CCSC_DONE, CCSC_BAD
  } ccsc_state_t;
  // Current level selection to the analog core; trickle, low_power and full are one-hot while enable is set
  typedef struct packed {
    logic enable;     // Any current delivered
    logic trickle;    // One tenth of full scale
    logic low_power;  // One fifth of full scale
    logic full;       // Full scale
    logic cv;         // Regulating at float voltage
  } ccsc_drive_t;
  // Comparator results
  typedef struct packed {
    logic below_trickle;
    logic below_recharge;
    logic at_float;
    logic below_tenth;
    logic temp_fault;
  } ccsc_comp_t;
endpackage
`default_nettype wire

/* hw/ccsc_top.sv */
/*
  Charger sequencing, safety timers and open-drain status encoder.
  Assumes comparator and pin levels are synchronous-enough levels; they are
  still passed through two flip-flops before use.
*/
`default_nettype none
module ccsc_top
  import ccsc_pkg::*;
#(
  parameter longint BADBAT_CYCLES = ccsc_pkg::BADBAT_CYC,
  parameter longint SAFETY_CYCLES = ccsc_pkg::SAFETY_CYC,
  parameter longint HALF_NTC      = ccsc_pkg::HALF_NTC_CYC,
  parameter longint HALF_BAD      = ccsc_pkg::HALF_BAD_CYC
) (
  input  wire logic                  MCLK,
  input  wire logic                  RST,
  input  wire logic                  CE,
  input  wire ccsc_pkg::ccsc_comp_t  COMP,
  input  wire logic                  CHARGE_SUSPEND_IN,
  input  wire logic                  HIGH_POWER_SELECT,
  input  wire logic                  POWER_GOOD,
  output logic                       CHARGE_STATUS_OUT_O,
  output logic                       CHARGE_STATUS_OUT_OE_N,
  output ccsc_pkg::ccsc_drive_t      DRIVE,
  output logic [2:0]                 PHASE
);
  import ccsc_pkg::*;

  // Two-stage synchroniser for every level input
  localparam int NS = 8;
  logic [NS-1:0] s1_q, s2_q, s1_d, s2_d;
  always_comb begin
    s1_d = {COMP, CHARGE_SUSPEND_IN, HIGH_POWER_SELECT, POWER_GOOD};
    s2_d = s1_q;
  end
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      s1_q <= '0;
      s2_q <= '0;
    end else if (CE) begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  // Decoded synchronised levels
  ccsc_comp_t c;
  logic charge_suspend_in, high_power_select, pgood;
  assign c     = ccsc_comp_t'(s2_q[7:3]);
  assign charge_suspend_in  = s2_q[2];
  assign high_power_select  = s2_q[1];
  assign pgood = s2_q[0];

  // Main state, counters, latches
  ccsc_state_t st_q, st_d;
  logic [TW-1:0] trk_q, trk_d;      // Time spent below trickle
  logic [TW-1:0] saf_q, saf_d;      // Safety timer
  logic [TW-1:0] dip_q, dip_d;      // Below-recharge dip filter
  logic          saf_run_q, saf_run_d;
  logic          bad_q, bad_d;      // Latched bad battery
  logic          rose_q, rose_d;    // Exceeded recharge since latch
  logic          rel_q, rel_d;      // Status pin released this cycle
  logic          live;
  logic          dip_long;

  // Charger is live only with power and no suspend
  assign live     = pgood && !charge_suspend_in;
  assign dip_long = dip_q >= TW'(DIP_CYC);

  // Sequencer next state
  always_comb begin
    st_d = st_q; trk_d = trk_q; saf_d = saf_q; dip_d = dip_q;
    saf_run_d = saf_run_q; bad_d = bad_q; rose_d = rose_q; rel_d = rel_q;
    if (!live) begin
      // Off: lockout or suspend restarts everything
      st_d = CCSC_OFF; trk_d = '0; saf_d = '0; dip_d = '0;
      saf_run_d = 1'b0; bad_d = 1'b0; rose_d = 1'b0; rel_d = 1'b0;
    end else begin
      // Dip filter on the recharge comparator
      dip_d = c.below_recharge ? (dip_long ? dip_q : dip_q + TW'(1)) : '0;
      if (!c.below_recharge && bad_q) rose_d = 1'b1;
      case (st_q)
        CCSC_OFF: st_d = c.below_trickle ? CCSC_TRICKLE : CCSC_CC;
        CCSC_TRICKLE: begin
          if (!c.below_trickle) begin
            st_d = CCSC_CC;
            trk_d = '0;
          end else if (bad_q && !rose_q) begin
            st_d = CCSC_BAD;
          end else if (!c.temp_fault) begin
            // Count only while charging; held during temperature pause
            if (trk_q >= TW'(BADBAT_CYCLES)) begin
              st_d = CCSC_BAD;
              bad_d = 1'b1;
              rose_d = 1'b0;
            end else begin
              trk_d = trk_q + TW'(1);
            end
          end
        end
        CCSC_CC: begin
          if (c.below_trickle) st_d = CCSC_TRICKLE;
          else if (c.at_float) st_d = CCSC_CV;
        end
        CCSC_CV: begin
          if (c.below_trickle) st_d = CCSC_TRICKLE;
          // Timer starts above recharge in CV
          if (!c.below_recharge) saf_run_d = 1'b1;
          if (saf_run_q) begin
            if (dip_long) begin
              saf_d = '0;
              saf_run_d = 1'b0;
            end else if (!c.temp_fault) begin
              if (saf_q >= TW'(SAFETY_CYCLES)) begin
                st_d = CCSC_DONE;
                saf_run_d = 1'b0;
                saf_d = '0;
              end else begin
                saf_d = saf_q + TW'(1);
              end
            end
          end
          if (c.below_tenth && !c.temp_fault) rel_d = 1'b1;
        end
        CCSC_DONE: begin
          // Stays off until battery sags below recharge the dip
          // filter only guards a running safety timer, so recharge starts at once
          if (c.below_recharge) begin
            st_d = CCSC_OFF;
            rel_d = 1'b0;
          end
        end
        CCSC_BAD: begin
          // Latched; charging resumes if the battery rises
          if (!c.below_trickle) begin
            st_d = CCSC_CC;
            trk_d = '0;
          end
        end
        default: st_d = CCSC_OFF;
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      st_q <= CCSC_OFF; trk_q <= '0; saf_q <= '0; dip_q <= '0;
      saf_run_q <= 1'b0; bad_q <= 1'b0; rose_q <= 1'b0; rel_q <= 1'b0;
    end else if (CE) begin
      st_q <= st_d; trk_q <= trk_d; saf_q <= saf_d; dip_q <= dip_d;
      saf_run_q <= saf_run_d; bad_q <= bad_d; rose_q <= rose_d; rel_q <= rel_d;
    end
  end

  // Carrier slot counter, sixteenth index, and blink half counter
  logic [15:0]   slot_q, slot_d;
  logic [3:0]    six_q, six_d;
  logic [TW-1:0] blk_q, blk_d;
  logic          phase_hi_q, phase_hi_d;
  logic [TW-1:0] half;
  logic          ntc_f, bad_f, fault;
  assign ntc_f = live && c.temp_fault && (st_q != CCSC_DONE) && (st_q != CCSC_OFF);
  assign bad_f = (st_q == CCSC_BAD);
  assign fault = ntc_f || bad_f;
  assign half  = bad_f ? TW'(HALF_BAD) : TW'(HALF_NTC);
  always_comb begin
    slot_d = slot_q + 16'h0001;
    six_d  = six_q;
    blk_d  = blk_q + TW'(1);
    phase_hi_d = phase_hi_q;
    if (slot_q >= 16'(SLOT_CYC - 1)) begin
      slot_d = 16'h0000;
      six_d  = six_q + 4'h1;
    end
    if (blk_q >= half - TW'(1)) begin
      blk_d = '0;
      phase_hi_d = !phase_hi_q;
    end
    if (!fault) begin
      blk_d = '0;
      phase_hi_d = 1'b0;
    end
  end
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      slot_q <= 16'h0000; six_q <= 4'h0; blk_q <= '0; phase_hi_q <= 1'b0;
    end else if (CE) begin
      slot_q <= slot_d; six_q <= six_d; blk_q <= blk_d; phase_hi_q <= phase_hi_d;
    end
  end

  // Status pin and drive outputs
  logic [3:0]  duty;
  logic        pull_d, pull_q;
  ccsc_drive_t drv_d, drv_q;
  always_comb begin
    // Duty pairs per fault
    if (bad_f) duty = phase_hi_q ? DUTY_BAD_HI : DUTY_BAD_LO;
    else       duty = phase_hi_q ? DUTY_NTC_HI : DUTY_NTC_LO;
    if (!live || st_q == CCSC_OFF || rel_q || st_q == CCSC_DONE)
      pull_d = 1'b0;                   // Released, faults ignored
    else if (fault)
      pull_d = six_q < duty;           // Pulsed carrier
    else
      pull_d = 1'b1;                   // Low while charging
    drv_d = '0;
    if (live && !c.temp_fault) begin   // Pause on temperature
      case (st_q)
        CCSC_TRICKLE: begin drv_d.enable = 1'b1; drv_d.trickle = 1'b1; end
        CCSC_CC, CCSC_CV: begin
          drv_d.enable    = 1'b1;
          drv_d.full      = high_power_select;
          drv_d.low_power = !high_power_select;
          drv_d.cv        = (st_q == CCSC_CV);
        end
        default: drv_d = '0;
      endcase
    end
  end
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pull_q <= 1'b0; drv_q <= '0;
    end else if (CE) begin
      pull_q <= pull_d; drv_q <= drv_d;
    end
  end

  // Open drain: enable low means pulling low
  assign CHARGE_STATUS_OUT_O    = 1'b0;
  assign CHARGE_STATUS_OUT_OE_N = !pull_q;
  assign DRIVE                  = drv_q;
  assign PHASE                  = st_q;
endmodule
`default_nettype wire

/* testbench/ccsc_checker.sv */
/*
  Concurrent checks on the charge cycle controller ports.
  Assumes one MCLK domain, reset RST active high, bound to ccsc_top.
*/
`default_nettype none
module ccsc_checker
  import ccsc_pkg::*;
(
  input wire logic                 MCLK,
  input wire logic                 RST,
  input wire logic                 CE,
  input wire ccsc_pkg::ccsc_comp_t COMP,
  input wire logic                 CHARGE_SUSPEND_IN,
  input wire logic                 HIGH_POWER_SELECT,
  input wire logic                 POWER_GOOD,
  input wire logic                 CHARGE_STATUS_OUT_O,
  input wire logic                 CHARGE_STATUS_OUT_OE_N,
  input wire ccsc_pkg::ccsc_drive_t DRIVE,
  input wire logic [2:0]           PHASE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // Six cycles cover the two sync flops plus state and output stages
  a_suspend_off: assert property (CHARGE_SUSPEND_IN [*6] |-> !DRIVE.enable && PHASE == 3'h0)
    else $error("suspend left current on");
  a_lockout_off: assert property (!POWER_GOOD [*6] |-> !DRIVE.enable && PHASE == 3'h0)
    else $error("lockout left charger on");
  a_trickle_drive: assert property ((PHASE == 3'h1 && !COMP.temp_fault) [*6] |-> DRIVE.trickle)
    else $error("trickle phase without trickle current");
  a_cc_level: assert property ((PHASE == 3'h2 && !COMP.temp_fault) [*6]
    |-> DRIVE.full == HIGH_POWER_SELECT && DRIVE.low_power == !HIGH_POWER_SELECT)
    else $error("constant current level wrong");
  a_charge_low: assert property ((PHASE == 3'h2 && !COMP.temp_fault) [*8]
    |-> !CHARGE_STATUS_OUT_OE_N)
    else $error("status pin not low while charging");
  a_od_data: assert property (CHARGE_STATUS_OUT_O == 1'b0)
    else $error("open drain data not low");
  a_temp_pause: assert property (COMP.temp_fault [*6] |-> !DRIVE.enable)
    else $error("current during temperature fault");
  a_done_idle: assert property ((PHASE == 3'h4) [*2] |-> !DRIVE.enable)
    else $error("current after termination");
  a_bad_idle: assert property ((PHASE == 3'h5) [*2] |-> !DRIVE.enable)
    else $error("current in bad battery state");
  a_bad_entry: assert property ($changed(PHASE) && PHASE == 3'h5
    |-> $past(PHASE) inside {3'h1, 3'h2})
    else $error("bad battery entered from wrong phase");
  c_bad: cover property (PHASE == 3'h5);
  c_done: cover property (PHASE == 3'h4);
  c_release: cover property (PHASE == 3'h3 && $rose(CHARGE_STATUS_OUT_OE_N));
endmodule
bind ccsc_top ccsc_checker u_ccsc_checker (.MCLK(MCLK), .RST(RST), .CE(CE), .COMP(COMP),
  .CHARGE_SUSPEND_IN(CHARGE_SUSPEND_IN), .HIGH_POWER_SELECT(HIGH_POWER_SELECT),
  .POWER_GOOD(POWER_GOOD), .CHARGE_STATUS_OUT_O(CHARGE_STATUS_OUT_O),
  .CHARGE_STATUS_OUT_OE_N(CHARGE_STATUS_OUT_OE_N), .DRIVE(DRIVE), .PHASE(PHASE));
`default_nettype wire

/* testbench/ccsc_status_decoder.sv */
/*
  Model of the processor that decodes the status pin by duty cycle.
  Assumes the pin carries a pull-up, so a released pin reads high.
*/
`default_nettype none
module ccsc_status_decoder
  import ccsc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic [2:0] kind   // 0 low, 1 released, 2 temp, 3 bad, 4 discarded, 7 none
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SL  = int'(SLOT_CYC);
  localparam int WIN = 16 * SL;
  int n;
  int lo;
  // A window of one carrier period sums the low time exactly wherever it starts
  function automatic logic [2:0] cls(input int l);
    if (l == WIN) return 3'h0;
    if (l == 0) return 3'h1;
    if (l == SL || l == 15 * SL) return 3'h2;
    if (l == 2 * SL || l == 14 * SL) return 3'h3;
    return 3'h4;  // Straddled a blink edge, half duty included: read again
  endfunction
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      n <= 0;
      lo <= 0;
      kind <= 3'h7;
    end else if (n == WIN - 1) begin
      n <= 0;
      lo <= 0;
      kind <= cls(lo + int'(!pin));
    end else begin
      n <= n + 1;
      lo <= lo + int'(!pin);
    end
  end
endmodule
`default_nettype wire

/* testbench/charge_cycle_status_controller_tb.sv */
/*
  Directed bench for the charge cycle controller and its status pin.
  Assumes sim values of the long counts; the dip filter is not shortened.
*/
`default_nettype none
module charge_cycle_status_controller_tb
  import ccsc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam longint BADC = 200;
  localparam longint SAFC = 300;
  localparam int     WIN  = 16 * int'(SLOT_CYC);
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, charge_suspend_in = 1'b0, high_power_select = 1'b1, pg = 1'b1;
  ccsc_comp_t  comp = 5'h18;      // Below trickle and below recharge
  ccsc_drive_t drive;
  logic        st_o, st_oe_n;
  logic [2:0]  phase, kind;
  wire  logic  pin = st_oe_n ? 1'b1 : st_o;   // Pull-up on the released pin
  int err_total = 0, n_tests = 0;
  // Each blink half spans two (bad) or three (temp) decoder windows, so one window always lies wholly inside it
  ccsc_top #(.BADBAT_CYCLES(BADC), .SAFETY_CYCLES(SAFC), .HALF_NTC(3 * WIN), .HALF_BAD(2 * WIN))
  u_ccsc_top (.MCLK(clk), .RST(rst), .CE(ce), .COMP(comp), .CHARGE_SUSPEND_IN(charge_suspend_in),
    .HIGH_POWER_SELECT(high_power_select), .POWER_GOOD(pg), .CHARGE_STATUS_OUT_O(st_o),
    .CHARGE_STATUS_OUT_OE_N(st_oe_n), .DRIVE(drive), .PHASE(phase));
  ccsc_status_decoder u_ccsc_status_decoder (.clk(clk), .rst(rst), .pin(pin), .kind(kind));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic conclude();
    if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic gap(input int c);
    repeat (c) @(negedge clk);
  endtask
  // Bounded waits: a run-out is a mismatch and closes the run
  task automatic waitph(input logic [2:0] p, input int lim);
    for (int i = 0; i < lim && phase !== p; i++) @(negedge clk);
    chk(phase === p, "phase not reached");
    if (phase !== p) conclude();
  endtask
  task automatic waitk(input logic [2:0] k);
    for (int i = 0; i < 5 * WIN && kind !== k; i++) @(negedge clk);
    chk(kind === k, "status pattern not seen");
    if (kind !== k) conclude();
  endtask
  task automatic t_trickle();
    waitph(3'h1, 10);
    gap(2);
    chk(drive.trickle === 1'b1 && st_oe_n === 1'b0, "trickle start");
  endtask
  task automatic t_cc();
    comp.below_trickle = 1'b0;
    waitph(3'h2, 10);
    gap(2);
    chk(drive.full === 1'b1 && drive.low_power === 1'b0, "full current");
    high_power_select = 1'b0;
    gap(6);
    chk(drive.low_power === 1'b1 && drive.full === 1'b0, "fifth current");
    high_power_select = 1'b1;
  endtask
  task automatic t_temp();
    comp.temp_fault = 1'b1;
    gap(6);
    chk(drive.enable === 1'b0, "temperature pause");
    waitk(3'h2);
    comp.temp_fault = 1'b0;
    gap(6);
    chk(drive.enable === 1'b1, "temperature resume");
  endtask
  task automatic t_cv_done();
    comp.below_recharge = 1'b0;
    comp.at_float = 1'b1;
    waitph(3'h3, 10);
    comp.below_tenth = 1'b1;
    gap(6);
    chk(st_oe_n === 1'b1, "release below tenth");
    comp.temp_fault = 1'b1;
    gap(20);
    chk(st_oe_n === 1'b1, "fault after release");
    comp.temp_fault = 1'b0;
    waitph(3'h4, int'(SAFC) + 60);
    gap(2);
    chk(drive.enable === 1'b0, "terminated");
    comp = 5'h08;  // Dropped below recharge only
    waitph(3'h2, 20);
  endtask
  task automatic t_bad();
    comp.below_trickle = 1'b1;
    waitph(3'h5, int'(BADC) + 50);
    waitk(3'h3);
    comp.below_trickle = 1'b0;
    waitph(3'h2, 10);
    comp.below_trickle = 1'b1;
    waitph(3'h5, 10);
    charge_suspend_in = 1'b1;
    gap(6);
    chk(phase === 3'h0 && drive.enable === 1'b0, "suspend off");
    charge_suspend_in = 1'b0;
    waitph(3'h1, 10);
    gap(50);
    chk(phase === 3'h1, "latch cleared by suspend");
  endtask
  task automatic t_power();
    pg = 1'b0;
    gap(6);
    chk(phase === 3'h0, "lockout stops");
    pg = 1'b1;
    waitph(3'h1, 10);
  endtask
  initial begin
    gap(2);
    rst = 1'b0;
    t_trickle();
    t_cc();
    t_temp();
    t_cv_done();
    t_bad();
    t_power();
    conclude();
  end
endmodule
`default_nettype wire
